// >>> hw/backlight_seq_pkg.sv
// shared constants for the backlight start-up sequencer and its host end
// assumes a single 10 MHz clock on both ends of the link
package backlight_seq_pkg;

  localparam int CLK_PERIOD_NS = 100;
  localparam int CNT_W         = 18;
  localparam int PH_W          = 12;
  localparam int CODE_W        = 9;
  localparam int FRAME_BITS    = 10;                  // ack request then code, msb first
  localparam logic [CODE_W-1:0] CODE_DEFAULT = 9'h1FF;

  // documented times, each in its own unit
  localparam int DETECT_DELAY_TIME_US    = 100;
  localparam int DETECT_LOW_TIME_US      = 260;
  localparam int DETECT_WINDOW_TIME_MS   = 1;
  localparam int REDUCED_LIMIT_PERIOD_MS = 5;
  localparam int EN_SHUTDOWN_MS_X10      = 25;        // 2.5 ms in tenths of a ms
  localparam int PWM_SHUTDOWN_MS         = 20;
  localparam int START_TIME_US           = 2;
  localparam int PHASE_MIN_US            = 2;
  localparam int SHORT_MAX_US            = 180;
  localparam int LONG_MAX_US             = 360;
  localparam int END_OF_STREAM_TIME_US   = 2;
  localparam int ACK_DURATION_US         = 512;

  // least times round up, longest times round down
  localparam int CUP = CLK_PERIOD_NS - 1;
  localparam logic [CNT_W-1:0] DETECT_DELAY_CYC  =
    CNT_W'((DETECT_DELAY_TIME_US * 1000 + CUP) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] DETECT_LOW_CYC    =
    CNT_W'((DETECT_LOW_TIME_US * 1000 + CUP) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] DETECT_WINDOW_CYC =
    CNT_W'((DETECT_WINDOW_TIME_MS * 1000000 + CUP) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] REDUCED_LIMIT_CYC =
    CNT_W'((REDUCED_LIMIT_PERIOD_MS * 1000000 + CUP) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] EN_SHUTDOWN_CYC   =
    CNT_W'((EN_SHUTDOWN_MS_X10 * 100000 + CUP) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] PWM_SHUTDOWN_CYC  =
    CNT_W'((PWM_SHUTDOWN_MS * 1000000 + CUP) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] ACK_DURATION_CYC  =
    CNT_W'((ACK_DURATION_US * 1000) / CLK_PERIOD_NS);
  localparam logic [PH_W-1:0] START_CYC     = PH_W'((START_TIME_US * 1000 + CUP) / CLK_PERIOD_NS);
  localparam logic [PH_W-1:0] PHASE_MIN_CYC = PH_W'((PHASE_MIN_US * 1000 + CUP) / CLK_PERIOD_NS);
  localparam logic [PH_W-1:0] SHORT_MAX_CYC = PH_W'((SHORT_MAX_US * 1000) / CLK_PERIOD_NS);
  localparam logic [PH_W-1:0] LONG_MAX_CYC  = PH_W'((LONG_MAX_US * 1000) / CLK_PERIOD_NS);
  localparam logic [PH_W-1:0] EOS_MIN_CYC   =
    PH_W'((END_OF_STREAM_TIME_US * 1000 + CUP) / CLK_PERIOD_NS);

  // host-side pattern, picked well inside the limits above
  localparam logic [CNT_W-1:0] HOST_WAKE_CYC   = 18'h005DC;  // 150 us before the low
  localparam logic [CNT_W-1:0] HOST_DETLOW_CYC = 18'h00BB8;  // 300 us low
  localparam logic [CNT_W-1:0] HOST_SETTLE_CYC = 18'h02EE0;  // 1.2 ms until writes
  localparam logic [CNT_W-1:0] HOST_START_CYC  = 18'h00064;  // 10 us
  localparam logic [CNT_W-1:0] HOST_SHORT_CYC  = 18'h000C8;  // 20 us
  localparam logic [CNT_W-1:0] HOST_LONG_CYC   = 18'h00258;  // 60 us
  localparam logic [CNT_W-1:0] HOST_EOS_CYC    = 18'h00064;  // 10 us
  localparam logic [CNT_W-1:0] HOST_ACKWT_CYC  = 18'h01770;  // 600 us

endpackage

// >>> hw/one_wire_link.sv
// enable line (open drain, pulled up by the host) and pwm line between the ends
// assumes both ends run on the same clock
`timescale 1ns/1ns
interface one_wire_link;
  logic enHostOut;
  logic enHostOe;
  logic enDevOe;
  logic pwmPin;
  logic enLine;

  // wired level: either end pulling low wins, released line floats high
  assign enLine = !(enDevOe || (enHostOe && !enHostOut));

  modport device (input enLine, input pwmPin, output enDevOe);
  modport host (input enLine, output enHostOut, output enHostOe, output pwmPin);
endinterface

// >>> hw/startup_and_one_wire_detect.sv
// start-up sequencer, interface detection and one-wire decoder of the driver
// assumes reset is the power-on reset and sink pins arrive asynchronously
// Functional notes
// (R1) start needs reset released, enable and pwm high
// (R2) detection window picks one-wire or pwm dimming
// (R3) one-wire needs 260us low after 100us, within 1ms
// (R4) grounded sink channels disabled after the window
// (R5) both sinks grounded: stay halted, no soft start
// (R6) then ramp compensation and enable switching
// (R7) reduced current limit first 5ms, then normal
// (R8) shutdown on enable low 2.5ms or pwm 20ms
// (R9) host zero bit: short high, double low
// (R10) host one bit: double high, short low
// (R11) host holds start condition at least 2us
// (R12) host holds end condition 2us to 360us
// (R13) ack pulls line low when requested, 512us max
// (R14) host uses open drain with its own pull-up
// (R15) code all ones when enabled or shut down
// (R16) host keeps the unused pin high
// (R17) all durations counted in oscillator cycles
`timescale 1ns/1ns
module startup_and_one_wire_detect
  import backlight_seq_pkg::*;
#(
  parameter logic [CNT_W-1:0] WINDOW_LEN  = DETECT_WINDOW_CYC,
  parameter logic [CNT_W-1:0] EN_OFF_LEN  = EN_SHUTDOWN_CYC,
  parameter logic [CNT_W-1:0] PWM_OFF_LEN = PWM_SHUTDOWN_CYC,
  parameter logic [CNT_W-1:0] LIMIT_LEN   = REDUCED_LIMIT_CYC,
  parameter logic [CNT_W-1:0] ACK_LEN     = ACK_DURATION_CYC
) (
  input  logic                sys_clk,
  input  logic                reset,
  one_wire_link.device        link,
  input  logic [1:0]          sinkFeedbackPin,
  output logic                oneWireSel,
  output logic                pwmDimSel,
  output logic [1:0]          sinkEnable,
  output logic                switchEnable,
  output logic                startupLimitSel,
  output logic                normalLimitSel,
  output logic                halted,
  output logic [CODE_W-1:0]   brightnessCode,
  output logic                codeStrobe
);

  typedef enum logic [2:0] {ST_OFF, ST_DETECT, ST_CHECK, ST_RUN, ST_HALT} seq_state_t;
  typedef enum logic [2:0] {DC_IDLE, DC_START, DC_HIGH, DC_LOW, DC_EOS, DC_ACK} dec_state_t;

  logic [3:0]            syncA, syncB, syncC, pinF, pinPrev, next_pinF;
  logic                  enF, pwmF, enRise, enFall;
  logic [1:0]            gndF;
  seq_state_t            seqState, next_seqState;
  logic [CNT_W-1:0]      mainCnt, next_mainCnt;
  logic [CNT_W-1:0]      enLowCnt, next_enLowCnt;
  logic [CNT_W-1:0]      pwmLowCnt, next_pwmLowCnt;
  logic                  lateLow, next_lateLow;
  logic                  next_oneWireSel, next_pwmDimSel, next_switchEnable;
  logic                  next_startupLimitSel, next_normalLimitSel, next_halted;
  logic [1:0]            next_sinkEnable;
  logic                  sdReq;
  dec_state_t            decState, next_decState;
  logic [PH_W-1:0]       phaseCnt, next_phaseCnt;
  logic [PH_W-1:0]       highLen, next_highLen;
  logic [FRAME_BITS-1:0] frame, next_frame;
  logic [3:0]            bitCnt, next_bitCnt;
  logic [CNT_W-1:0]      ackCnt, next_ackCnt;
  logic                  ackDrive, next_ackDrive;
  logic [CODE_W-1:0]     next_brightnessCode;
  logic                  next_codeStrobe;
  logic                  bit0Ok, bit1Ok;

  // pin filter: a change counts once the second and third stage agree
  always_comb begin
    next_pinF = (syncB & syncC) | (pinF & (syncB | syncC));
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      syncA   <= 4'h0;
      syncB   <= 4'h0;
      syncC   <= 4'h0;
      pinF    <= 4'h0;
      pinPrev <= 4'h0;
    end else begin
      syncA   <= {sinkFeedbackPin, link.pwmPin, link.enLine};
      syncB   <= syncA;
      syncC   <= syncB;
      pinF    <= next_pinF;
      pinPrev <= pinF;
    end
  end

  assign enF    = pinF[0];
  assign pwmF   = pinF[1];
  assign gndF   = pinF[3:2];
  assign enRise = enF & ~pinPrev[0];
  assign enFall = ~enF & pinPrev[0];
  assign sdReq  = (enLowCnt >= EN_OFF_LEN) || (pwmLowCnt >= PWM_OFF_LEN);

  // start-up sequencer; low-time counters saturate so they never wrap
  always_comb begin
    next_seqState   = seqState;
    next_mainCnt    = mainCnt;
    next_lateLow    = lateLow;
    next_oneWireSel = oneWireSel;
    next_pwmDimSel  = pwmDimSel;
    next_sinkEnable = sinkEnable;
    next_enLowCnt   = enF ? '0 : (sdReq && enLowCnt >= EN_OFF_LEN) ? enLowCnt :
                      CNT_W'(enLowCnt + 1'b1); // (R17)
    next_pwmLowCnt  = pwmF ? '0 : (pwmLowCnt >= PWM_OFF_LEN) ? pwmLowCnt :
                      CNT_W'(pwmLowCnt + 1'b1);
    case (seqState)
      ST_OFF: begin
        if (enF && pwmF) begin // (R1)
          next_seqState   = ST_DETECT;
          next_mainCnt    = '0;
          next_lateLow    = 1'b0;
          next_oneWireSel = 1'b0;
        end
      end
      ST_DETECT: begin
        next_mainCnt = CNT_W'(mainCnt + 1'b1);
        if (enFall) begin
          next_lateLow = (mainCnt >= DETECT_DELAY_CYC); // (R3)
        end
        if (!enF && lateLow && enLowCnt == DETECT_LOW_CYC) begin
          next_oneWireSel = 1'b1; // (R2) (R3)
        end
        if (mainCnt >= WINDOW_LEN - 1'b1) begin
          next_seqState = ST_CHECK; // (R2)
        end
      end
      ST_CHECK: begin
        next_sinkEnable = ~gndF; // (R4)
        next_pwmDimSel  = ~oneWireSel; // (R2)
        next_mainCnt    = '0;
        next_seqState   = (&gndF) ? ST_HALT : ST_RUN; // (R5) (R6)
      end
      ST_RUN: begin
        if (mainCnt < LIMIT_LEN) begin
          next_mainCnt = CNT_W'(mainCnt + 1'b1); // (R7)
        end
      end
      ST_HALT: begin
        next_mainCnt = mainCnt; // (R5)
      end
      default: begin
        next_seqState = ST_OFF;
      end
    endcase
    if (seqState != ST_OFF && sdReq) begin
      next_seqState   = ST_OFF; // (R8)
      next_oneWireSel = 1'b0;
      next_pwmDimSel  = 1'b0;
      next_sinkEnable = 2'h0;
    end
    // comp ramp and boost switching are released together
    next_switchEnable    = (next_seqState == ST_RUN); // (R6)
    next_startupLimitSel = next_switchEnable && (next_mainCnt < LIMIT_LEN); // (R7)
    next_normalLimitSel  = next_switchEnable && (next_mainCnt >= LIMIT_LEN); // (R7)
    next_halted          = (next_seqState == ST_HALT);
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      seqState        <= ST_OFF;
      mainCnt         <= '0;
      enLowCnt        <= '0;
      pwmLowCnt       <= '0;
      lateLow         <= 1'b0;
      oneWireSel      <= 1'b0;
      pwmDimSel       <= 1'b0;
      sinkEnable      <= 2'h0;
      switchEnable    <= 1'b0;
      startupLimitSel <= 1'b0;
      normalLimitSel  <= 1'b0;
      halted          <= 1'b0;
    end else begin
      seqState        <= next_seqState;
      mainCnt         <= next_mainCnt;
      enLowCnt        <= next_enLowCnt;
      pwmLowCnt       <= next_pwmLowCnt;
      lateLow         <= next_lateLow;
      oneWireSel      <= next_oneWireSel;
      pwmDimSel       <= next_pwmDimSel;
      sinkEnable      <= next_sinkEnable;
      switchEnable    <= next_switchEnable;
      startupLimitSel <= next_startupLimitSel;
      normalLimitSel  <= next_normalLimitSel;
      halted          <= next_halted;
    end
  end

  // bit class from the high length and the low length just ended
  assign bit0Ok = (highLen >= PHASE_MIN_CYC) && (highLen <= SHORT_MAX_CYC) &&
                  ({1'b0, phaseCnt} >= {highLen, 1'b0}) && (phaseCnt <= LONG_MAX_CYC);
  assign bit1Ok = (phaseCnt >= PHASE_MIN_CYC) && (phaseCnt <= SHORT_MAX_CYC) &&
                  ({1'b0, highLen} >= {phaseCnt, 1'b0}) && (highLen <= LONG_MAX_CYC);

  // one-wire decoder; any malformed phase drops the frame silently
  always_comb begin
    next_decState       = decState;
    next_highLen        = highLen;
    next_frame          = frame;
    next_bitCnt         = bitCnt;
    next_ackCnt         = ackCnt;
    next_ackDrive       = ackDrive;
    next_brightnessCode = brightnessCode;
    next_codeStrobe     = 1'b0;
    next_phaseCnt       = (enRise || enFall) ? '0 : (&phaseCnt) ? phaseCnt :
                          PH_W'(phaseCnt + 1'b1);
    case (decState)
      DC_IDLE: begin
        if (!enF && phaseCnt >= START_CYC) begin
          next_decState = DC_START;
        end
      end
      DC_START: begin
        if (enRise) begin
          next_decState = DC_HIGH;
          next_bitCnt   = 4'h0;
        end
      end
      DC_HIGH: begin
        if (enFall) begin
          next_highLen  = phaseCnt;
          next_decState = DC_LOW;
        end else if (phaseCnt > LONG_MAX_CYC) begin
          next_decState = DC_IDLE;
        end
      end
      DC_LOW: begin
        if (enRise) begin
          if (bit0Ok || bit1Ok) begin
            next_frame    = {frame[FRAME_BITS-2:0], bit1Ok};
            next_bitCnt   = 4'(bitCnt + 1'b1);
            next_decState = (bitCnt == 4'(FRAME_BITS - 1)) ? DC_EOS : DC_HIGH;
          end else begin
            next_decState = DC_IDLE;
          end
        end else if (phaseCnt > LONG_MAX_CYC) begin
          next_decState = DC_IDLE;
        end
      end
      DC_EOS: begin
        if (!enF) begin
          next_decState = DC_IDLE;
        end else if (phaseCnt >= EOS_MIN_CYC) begin
          next_brightnessCode = frame[CODE_W-1:0];
          next_codeStrobe     = 1'b1;
          next_ackCnt         = '0;
          next_ackDrive       = frame[FRAME_BITS-1]; // (R13)
          next_decState       = frame[FRAME_BITS-1] ? DC_ACK : DC_IDLE;
        end
      end
      DC_ACK: begin
        // own pull-down must clear the filter before idle sees the line
        if (ackDrive) begin
          next_ackCnt = CNT_W'(ackCnt + 1'b1);
          if (ackCnt >= ACK_LEN - 1'b1) begin
            next_ackDrive = 1'b0; // (R13)
          end
        end else if (enF) begin
          next_decState = DC_IDLE;
        end
      end
      default: begin
        next_decState = DC_IDLE;
      end
    endcase
    if (seqState != ST_RUN || !oneWireSel) begin
      next_decState = DC_IDLE;
      next_ackDrive = 1'b0;
    end
    if (next_seqState == ST_OFF) begin
      next_brightnessCode = CODE_DEFAULT; // (R15)
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      decState       <= DC_IDLE;
      phaseCnt       <= '0;
      highLen        <= '0;
      frame          <= '0;
      bitCnt         <= 4'h0;
      ackCnt         <= '0;
      ackDrive       <= 1'b0;
      brightnessCode <= CODE_DEFAULT;
      codeStrobe     <= 1'b0;
    end else begin
      decState       <= next_decState;
      phaseCnt       <= next_phaseCnt;
      highLen        <= next_highLen;
      frame          <= next_frame;
      bitCnt         <= next_bitCnt;
      ackCnt         <= next_ackCnt;
      ackDrive       <= next_ackDrive;
      brightnessCode <= next_brightnessCode;
      codeStrobe     <= next_codeStrobe;
    end
  end

  assign link.enDevOe = ackDrive; // (R13)

endmodule // startup_and_one_wire_detect

// >>> hw/backlight_host_end.sv
// host end: drives enable and pwm lines and sends one-wire brightness frames
// assumes the same clock as the device end and a pull-up in the link
`timescale 1ns/1ns
module backlight_host_end
  import backlight_seq_pkg::*;
(
  input  logic                sys_clk,
  input  logic                reset,
  one_wire_link.host          link,
  input  logic                powerUp,
  input  logic                useOneWire,
  input  logic                powerDown,
  input  logic                pwmLevel,
  input  logic                writeReq,
  input  logic [CODE_W-1:0]   writeCode,
  input  logic                writeAck,
  output logic                ready,
  output logic                writeDone,
  output logic                ackSeen
);

  typedef enum logic [3:0] {H_OFF, H_WAKE, H_READY, H_START, H_BITHI, H_BITLO, H_EOS,
                            H_ACKWAIT} host_state_t;

  host_state_t           state, next_state;
  logic [CNT_W-1:0]      cnt, next_cnt;
  logic                  mode, next_mode;
  logic [FRAME_BITS-1:0] shift, next_shift;
  logic [3:0]            bitIdx, next_bitIdx;
  logic                  pullLow, next_pullLow;
  logic                  pwmOut, next_pwmOut;
  logic                  next_ready, next_writeDone, next_ackSeen;
  logic                  syncA, syncB, syncC, lineF, next_lineF;
  logic [CNT_W-1:0]      phaseLen;

  // line filter; the first stage feeds only the second
  always_comb begin
    next_lineF = (syncB & syncC) | (lineF & (syncB | syncC));
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      syncA <= 1'b0;
      syncB <= 1'b0;
      syncC <= 1'b0;
      lineF <= 1'b0;
    end else begin
      syncA <= link.enLine;
      syncB <= syncA;
      syncC <= syncB;
      lineF <= next_lineF;
    end
  end

  // long phase for the level that carries the bit value
  assign phaseLen = ((state == H_BITHI) == shift[FRAME_BITS-1]) ? HOST_LONG_CYC :
                    HOST_SHORT_CYC; // (R9) (R10)

  always_comb begin
    next_state     = state;
    next_cnt       = CNT_W'(cnt + 1'b1);
    next_mode      = mode;
    next_shift     = shift;
    next_bitIdx    = bitIdx;
    next_pullLow   = pullLow;
    next_pwmOut    = pwmOut;
    next_writeDone = 1'b0;
    next_ackSeen   = ackSeen;
    case (state)
      H_OFF: begin
        if (powerUp) begin
          next_state   = H_WAKE;
          next_cnt     = '0;
          next_mode    = useOneWire;
          next_pullLow = 1'b0;
          next_pwmOut  = 1'b1;
        end
      end
      H_WAKE: begin
        // low pattern sits inside the detection window, writes wait for its end
        next_pullLow = mode && (cnt >= HOST_WAKE_CYC) &&
                       (cnt < HOST_WAKE_CYC + HOST_DETLOW_CYC); // (R3)
        if (cnt >= HOST_SETTLE_CYC) begin
          next_state = H_READY;
        end
      end
      H_READY: begin
        next_pwmOut = mode ? 1'b1 : pwmLevel; // (R16)
        if (powerDown) begin
          next_state   = H_OFF;
          next_pullLow = 1'b1; // pwm left as is: enable alone times the off
        end else if (writeReq && mode) begin
          next_state   = H_START;
          next_cnt     = '0;
          next_shift   = {writeAck, writeCode};
          next_bitIdx  = 4'h0;
          next_pullLow = 1'b1;
          next_ackSeen = 1'b0;
        end
      end
      H_START: begin
        if (cnt >= HOST_START_CYC - 1'b1) begin
          next_state   = H_BITHI; // (R11)
          next_cnt     = '0;
          next_pullLow = 1'b0;
        end
      end
      H_BITHI: begin
        if (cnt >= phaseLen - 1'b1) begin
          next_state   = H_BITLO;
          next_cnt     = '0;
          next_pullLow = 1'b1;
        end
      end
      H_BITLO: begin
        if (cnt >= phaseLen - 1'b1) begin
          next_cnt     = '0;
          next_pullLow = 1'b0;
          next_shift   = {shift[FRAME_BITS-2:0], 1'b0};
          next_bitIdx  = 4'(bitIdx + 1'b1);
          next_state   = (bitIdx == 4'(FRAME_BITS - 1)) ? H_EOS : H_BITHI;
        end
      end
      H_EOS: begin
        if (!lineF && cnt >= CNT_W'(EOS_MIN_CYC)) begin // filter lags the last rise
          next_ackSeen = 1'b1;
        end
        if (cnt >= HOST_EOS_CYC - 1'b1) begin
          next_cnt   = '0;
          next_state = H_ACKWAIT; // (R12)
        end
      end
      H_ACKWAIT: begin
        // wait out the device pull-down before the next frame
        if (lineF || cnt >= HOST_ACKWT_CYC) begin
          next_state     = H_READY;
          next_writeDone = 1'b1;
        end
      end
      default: begin
        next_state = H_OFF;
      end
    endcase
    next_ready = (next_state == H_READY);
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state     <= H_OFF;
      cnt       <= '0;
      mode      <= 1'b0;
      shift     <= '0;
      bitIdx    <= 4'h0;
      pullLow   <= 1'b1;
      pwmOut    <= 1'b0;
      ready     <= 1'b0;
      writeDone <= 1'b0;
      ackSeen   <= 1'b0;
    end else begin
      state     <= next_state;
      cnt       <= next_cnt;
      mode      <= next_mode;
      shift     <= next_shift;
      bitIdx    <= next_bitIdx;
      pullLow   <= next_pullLow;
      pwmOut    <= next_pwmOut;
      ready     <= next_ready;
      writeDone <= next_writeDone;
      ackSeen   <= next_ackSeen;
    end
  end

  // open drain: only ever drive low, the pull-up gives the high (R14)
  assign link.enHostOut = 1'b0;
  assign link.enHostOe  = pullLow;
  assign link.pwmPin    = pwmOut;

endmodule // backlight_host_end

// >>> verif/one_wire_monitor.sv
// wire-level checks on the link between the host end and the device end
// assumes one shared clock and the shared async active-high reset
`timescale 1ns/1ns
module one_wire_monitor
  import backlight_seq_pkg::*;
#(
  parameter logic [CNT_W-1:0] ACK_LEN = ACK_DURATION_CYC
) (
  input logic sys_clk,
  input logic reset,
  input logic enHostOut,
  input logic enHostOe,
  input logic enDevOe,
  input logic pwmPin,
  input logic enLine
);
  logic [CNT_W-1:0] ackCnt, next_ackCnt;
  logic [PH_W-1:0]  hiCnt, loCnt, next_hiCnt, next_loCnt;

  // run lengths of each line level; saturating so long idles never wrap
  always_comb begin
    next_ackCnt = enDevOe ? ackCnt + 1'b1 : '0;
    next_hiCnt = !enLine ? '0 : (&hiCnt) ? hiCnt : hiCnt + 1'b1;
    next_loCnt = enLine ? '0 : (&loCnt) ? loCnt : loCnt + 1'b1;
  end

  // reset holds the line low, so the low run counts as long already
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ackCnt <= '0;
      hiCnt <= '0;
      loCnt <= '1;
    end else begin
      ackCnt <= next_ackCnt;
      hiCnt <= next_hiCnt;
      loCnt <= next_loCnt;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  ack_length_a: assert property (enDevOe |-> ackCnt < ACK_LEN)
    else $error("ack pull-down held too long");
  ack_release_a: assert property ($fell(enDevOe) |-> ackCnt == ACK_LEN)
    else $error("ack pull-down length wrong");
  ack_after_end_a: assert property ($rose(enDevOe) |-> hiCnt >= EOS_MIN_CYC)
    else $error("ack before end condition");
  ack_with_pwm_a: assert property (enDevOe |-> pwmPin)
    else $error("ack while pwm line low");
  ack_no_fight_a: assert property (enDevOe |-> !enHostOe)
    else $error("host pulls line during ack");
  open_drain_a: assert property (!enHostOut)
    else $error("host drives line high");
  high_phase_a: assert property ($rose(enHostOe) |-> hiCnt >= PHASE_MIN_CYC)
    else $error("high phase too short");
  low_phase_a: assert property ($fell(enHostOe) |-> loCnt >= PHASE_MIN_CYC)
    else $error("low phase too short");
endmodule // one_wire_monitor

// >>> verif/startup_and_one_wire_detect_tb.sv
// bench joining device end and host end over the one-wire link
// assumes a 10 MHz clock and both ends on one async reset
`timescale 1ns/1ns
module startup_and_one_wire_detect_tb
  import backlight_seq_pkg::*;
;
  localparam logic [CNT_W-1:0] EN_OFF  = 18'h00FA0;
  localparam logic [CNT_W-1:0] PWM_OFF = 18'h001F4;
  localparam logic [CNT_W-1:0] LIM     = 18'h00064;
  localparam logic [CNT_W-1:0] ACK_L   = 18'h00032;
  typedef struct packed {
    logic              ack;
    logic [CODE_W-1:0] code;
    logic [CODE_W-1:0] expCode;
    logic              expAck;
  } row_t;
  logic              sys_clk = 1'b0;
  logic              reset, powerUp, useOneWire, powerDown, pwmLevel, writeReq, writeAck, sb;
  logic [CODE_W-1:0] writeCode, brightnessCode;
  logic [1:0]        sinkFeedbackPin, sinkEnable;
  logic              oneWireSel, pwmDimSel, switchEnable, startupLimitSel, normalLimitSel;
  logic              halted, codeStrobe, ready, writeDone, ackSeen;
  logic [5:0]        mon;
  int                fail_count, checks_done, n;
  row_t              rows [3] = '{'{1'b1, 9'h000, 9'h000, 1'b1},
    '{1'b0, 9'h155, 9'h155, 1'b0}, '{1'b1, 9'h0AA, 9'h0AA, 1'b1}};

  always #50 sys_clk = ~sys_clk;
  // waitable conditions, picked by index
  assign mon = {halted, normalLimitSel, ~switchEnable, switchEnable, ready, writeDone};

  one_wire_link one_wire_link_i ();
  startup_and_one_wire_detect #(.EN_OFF_LEN(EN_OFF), .PWM_OFF_LEN(PWM_OFF),
    .LIMIT_LEN(LIM), .ACK_LEN(ACK_L)) startup_and_one_wire_detect_i (
    .sys_clk(sys_clk), .reset(reset), .link(one_wire_link_i),
    .sinkFeedbackPin(sinkFeedbackPin), .oneWireSel(oneWireSel), .pwmDimSel(pwmDimSel),
    .sinkEnable(sinkEnable), .switchEnable(switchEnable), .startupLimitSel(startupLimitSel),
    .normalLimitSel(normalLimitSel), .halted(halted), .brightnessCode(brightnessCode),
    .codeStrobe(codeStrobe));
  backlight_host_end backlight_host_end_i (.sys_clk(sys_clk), .reset(reset),
    .link(one_wire_link_i), .powerUp(powerUp), .useOneWire(useOneWire),
    .powerDown(powerDown), .pwmLevel(pwmLevel), .writeReq(writeReq), .writeCode(writeCode),
    .writeAck(writeAck), .ready(ready), .writeDone(writeDone), .ackSeen(ackSeen));
  one_wire_monitor #(.ACK_LEN(ACK_L)) one_wire_monitor_i (.sys_clk(sys_clk), .reset(reset),
    .enHostOut(one_wire_link_i.enHostOut), .enHostOe(one_wire_link_i.enHostOe),
    .enDevOe(one_wire_link_i.enDevOe), .pwmPin(one_wire_link_i.pwmPin),
    .enLine(one_wire_link_i.enLine));

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [17:0] ex, input logic [17:0] got);
    checks_done++;
    if (got !== ex) begin
      fail_count++;
      $display("[ERR] %s expected %0h seen %0h", nm, ex, got);
    end
  endtask

  // bounded wait on a condition; a hang ends the run as a mismatch
  task automatic waitBit(input int k, input int lim);
    n = 0;
    while (mon[k] !== 1'b1 && n < lim) begin
      @(negedge sys_clk);
      n++;
      sb |= codeStrobe;
    end
    chk("waitCond", 1, mon[k]);
    if (mon[k] !== 1'b1) print_verdict;
  endtask

  task automatic pulse(input int which);
    @(posedge sys_clk) if (which == 0) powerUp <= 1'b1; else powerDown <= 1'b1;
    @(posedge sys_clk) {powerUp, powerDown} <= 2'b00;
  endtask

  initial begin
    {reset, powerUp, useOneWire, powerDown, pwmLevel, writeReq, writeAck} = 7'h41;
    writeCode = '0;
    sinkFeedbackPin = 2'b00;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    @(negedge sys_clk);
    chk("resetCode", CODE_DEFAULT, brightnessCode);
    chk("resetSw", 0, switchEnable);
    // one-wire start with channel 0 grounded
    @(posedge sys_clk) {useOneWire, sinkFeedbackPin} <= 3'h5;
    pulse(0);
    waitBit(2, 13000);
    chk("oneWireSel", 2'b10, {oneWireSel, pwmDimSel});
    chk("sinkEnable", 2'b10, sinkEnable);
    chk("startLimit", 2'b10, {startupLimitSel, normalLimitSel});
    waitBit(4, 200);
    chk("limitLen", 1, n >= LIM - 1 && n <= LIM + 1);
    waitBit(1, 5000);
    $display("test oneWireStart done");
    // ordinary frames, acknowledged and not
    foreach (rows[i]) begin
      sb = 1'b0;
      repeat (30) @(negedge sys_clk); // line sits high before the start
      @(posedge sys_clk) {writeReq, writeAck, writeCode} <= {1'b1, rows[i].ack, rows[i].code};
      @(posedge sys_clk) writeReq <= 1'b0;
      waitBit(0, 20000);
      chk("strobe", 1, sb);
      chk("code", rows[i].expCode, brightnessCode);
      chk("ackSeen", rows[i].expAck, ackSeen);
    end
    $display("test frames done");
    pulse(1);
    waitBit(3, EN_OFF + 100);
    chk("enOffLen", 1, n >= EN_OFF);
    chk("offCode", CODE_DEFAULT, brightnessCode);
    chk("offSel", 0, oneWireSel);
    $display("test enShutdown done");
    // pwm dimming: frames refused, pwm low shuts down
    @(posedge sys_clk) {useOneWire, sinkFeedbackPin, pwmLevel} <= 4'h1;
    pulse(0);
    waitBit(1, 13000);
    chk("pwmSel", 2'b01, {oneWireSel, pwmDimSel});
    chk("sinkBoth", 2'b11, sinkEnable);
    sb = 1'b0;
    @(posedge sys_clk) {writeReq, writeCode} <= {1'b1, 9'h000};
    @(posedge sys_clk) writeReq <= 1'b0;
    repeat (300) @(negedge sys_clk) sb |= codeStrobe;
    chk("pwmNoFrame", 0, sb);
    @(posedge sys_clk) pwmLevel <= 1'b0;
    waitBit(3, PWM_OFF + 100);
    chk("pwmOffLen", 1, n >= PWM_OFF);
    $display("test pwmMode done");
    // enable high, pwm low: no restart; both sinks grounded then halts
    @(posedge sys_clk) sinkFeedbackPin <= 2'b11;
    repeat (10200) @(negedge sys_clk);
    chk("pwmLowOff", 2'b00, {switchEnable, halted});
    @(posedge sys_clk) pwmLevel <= 1'b1;
    waitBit(5, 10200);
    chk("haltSw", 3'b000, {switchEnable, sinkEnable});
    $display("test haltBoth done");
    print_verdict;
  end
endmodule // startup_and_one_wire_detect_tb
